// File: hdl/pwm_pkg.sv
// Contract
// - output repeats at system clock over prescale ratio times period value
// - shortest pulse is one counter clock
// - longest non-steady pulse is period minus one counter clocks
// - width zero holds output cleared, no pulses
// - width at or above period holds output set
// - steady 0% and 100% levels follow the output polarity bit
// - period zero means 65536 clocks; widest pulse then 65535 clocks
// - counter keeps running and wrapping during steady output
// - unused bits other than config bits 5:3, and reserved addresses, read zero, writes ignored
// - four independent pulse submodules, each with its own registers
// - up to eleven interrupt sources, each on one of seven levels
// - each submodule holds a 3-bit level and 1-bit arbitration number
// - level selects which of seven request lines the submodule drives
// - arbitration value is submodule bit plus three module config bits
// - lowest-numbered pending submodule wins at the arbitrated level
// - vector is two config bits followed by six-bit submodule number
// - submodules numbered 0 to 12, eight bytes apart; pulse ones are 5 to 8
// - upper address nibble is module-map bit then three ones
// - counter held at one when disabled, counts up, presets to one on period match
// - output set at period match, cleared at width match
// - next values copied at period start or at once on load bit
// - flag set at each period start; non-zero level enables request
`default_nettype none
package pwm_pkg;
    localparam int unsigned PWM_NUM_SM = 4;
    localparam logic [5:0] PWM_FIRST_SM_NUM = 6'h05;
    localparam logic [11:0] PWM_BIU_BASE = 12'h400;
    localparam logic [11:0] PWM_SM_STRIDE = 12'h008;
    localparam logic [11:0] PWM_REG_SIC = 12'h000;
    localparam logic [11:0] PWM_REG_PERIOD = 12'h002;
    localparam logic [11:0] PWM_REG_WIDTH = 12'h004;
    localparam logic [11:0] PWM_REG_COUNT = 12'h006;
    localparam logic [11:0] PWM_REG_BIU_CFG = 12'h000;
    localparam logic [11:0] PWM_REG_PRESCALE = 12'h008;
    localparam int PWM_SIC_CLK_LSB = 0;
    localparam int PWM_SIC_LOAD_BIT = 3;
    localparam int PWM_SIC_EN_BIT = 4;
    localparam int PWM_SIC_POL_BIT = 5;
    localparam int PWM_SIC_PIN_BIT = 6;
    localparam int PWM_SIC_ARB_BIT = 11;
    localparam int PWM_SIC_IL_LSB = 12;
    localparam int PWM_SIC_FLAG_BIT = 15;
    localparam int PWM_BIU_ARB_LSB = 0;
    localparam int PWM_BIU_VEC_LSB = 6;
    localparam logic [15:0] PWM_COUNT_RESET = 16'h0001;
    localparam logic [15:0] PWM_SIC_RESET = 16'h0000;
    localparam logic [3:0] PWM_ADDR_NIBBLE_ONES = 4'h7;
    localparam logic [1:0] PWM_COUNTER_PRESCALER_SUBMODULE_DIV2 = 2'h2;
    localparam logic [1:0] PWM_COUNTER_PRESCALER_SUBMODULE_DIV3 = 2'h3;
endpackage : pwm_pkg
`default_nettype wire

// File: hdl/pwm_channel.sv
`default_nettype none
module pwm_channel
    import pwm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic pclk_en,
    input wire logic [15:0] sic_wdata,
    input wire logic sic_we,
    input wire logic period_we,
    input wire logic width_we,
    input wire logic [15:0] wdata,
    output logic [15:0] sic_rdata,
    output logic [15:0] period_rdata,
    output logic [15:0] width_rdata,
    output logic [15:0] count_rdata,
    output logic pwm_out,
    output logic irq_req,
    output logic [2:0] irq_level,
    output logic arb_bit
);
    import pwm_pkg::*;

    typedef struct packed {
        logic [7:0] pre;
        logic [2:0] clk_sel;
        logic en;
        logic output_polarity;
        logic arb;
        logic [2:0] il;
        logic flag;
        logic [15:0] period_next_reg;
        logic [15:0] period_active_reg;
        logic [15:0] width_next_reg;
        logic [15:0] width_active_reg;
        logic [15:0] pulse_counter_reg;
        logic ff;
    } pwm_ch_type;

    pwm_ch_type r;
    pwm_ch_type next_r;
    logic tick;
    logic period_match;

    // counter clock tap: divides 1,2,4..64 then 256 of the module rate
    always_comb
    begin
        case (r.clk_sel)
            3'h0: tick = pclk_en;
            3'h1: tick = pclk_en && (r.pre[0] == 1'b1);
            3'h2: tick = pclk_en && (r.pre[1:0] == 2'h3);
            3'h3: tick = pclk_en && (r.pre[2:0] == 3'h7);
            3'h4: tick = pclk_en && (r.pre[3:0] == 4'hf);
            3'h5: tick = pclk_en && (r.pre[4:0] == 5'h1f);
            3'h6: tick = pclk_en && (r.pre[5:0] == 6'h3f);
            default: tick = pclk_en && (r.pre == 8'hff);
        endcase
    end

    // period zero stands for 65536 counter clocks: the match is the wrap to zero
    assign period_match = (r.period_active_reg == 16'h0000)
        ? (r.pulse_counter_reg == 16'h0000)
        : (r.pulse_counter_reg == r.period_active_reg);

    always_comb
    begin
        next_r = r;
        if (pclk_en)
        begin
            next_r.pre = r.pre + 8'h01;
        end
        // counter and output sequencing
        if (!r.en)
        begin
            next_r.pulse_counter_reg = PWM_COUNT_RESET;
            next_r.pre = 8'h00;
            next_r.ff = 1'b0;
        end
        else if (tick)
        begin
            if (period_match)
            begin
                // period start: counter wraps even in steady output
                next_r.pulse_counter_reg = PWM_COUNT_RESET;
                next_r.flag = 1'b1;
                // a write landing on this edge waits one period, so no half-new pair
                if (!(period_we || width_we))
                begin
                    next_r.period_active_reg = r.period_next_reg;
                    next_r.width_active_reg = r.width_next_reg;
                end
                next_r.ff = 1'b1;
            end
            else
            begin
                next_r.pulse_counter_reg = r.pulse_counter_reg + 16'h0001;
                if (r.pulse_counter_reg == r.width_active_reg)
                begin
                    next_r.ff = 1'b0;
                end
            end
        end
        // software writes; a hardware set of a clear flag wins over a clear
        if (sic_we)
        begin
            next_r.clk_sel = sic_wdata[PWM_SIC_CLK_LSB +: 3];
            next_r.en = sic_wdata[PWM_SIC_EN_BIT];
            next_r.output_polarity = sic_wdata[PWM_SIC_POL_BIT];
            next_r.arb = sic_wdata[PWM_SIC_ARB_BIT];
            next_r.il = sic_wdata[PWM_SIC_IL_LSB +: 3];
            if (!sic_wdata[PWM_SIC_FLAG_BIT] && !(next_r.flag && !r.flag))
            begin
                next_r.flag = 1'b0;
            end
            if (sic_wdata[PWM_SIC_LOAD_BIT])
            begin
                next_r.period_active_reg = r.period_next_reg;
                next_r.width_active_reg = r.width_next_reg;
            end
        end
        // next values may be written at any time
        if (period_we)
        begin
            next_r.period_next_reg = wdata;
        end
        if (width_we)
        begin
            next_r.width_next_reg = wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '0;
            r.pulse_counter_reg <= PWM_COUNT_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    logic steady_lo;
    logic steady_hi;
    logic level;
    assign steady_lo = (r.width_active_reg == 16'h0000);
    assign steady_hi = (r.period_active_reg != 16'h0000)
        && (r.width_active_reg >= r.period_active_reg);
    assign level = !r.en ? 1'b0 : steady_lo ? 1'b0 : steady_hi ? 1'b1 : r.ff;
    // polarity sets the pin level in every case, also when idle
    assign pwm_out = level ^ ~r.output_polarity;

    assign sic_rdata = {r.flag, r.il, r.arb, 4'h0, level ^ ~r.output_polarity, r.output_polarity, r.en,
        1'b0, r.clk_sel};
    assign period_rdata = r.period_next_reg;
    assign width_rdata = r.width_next_reg;
    assign count_rdata = r.pulse_counter_reg;
    assign irq_req = r.flag && (r.il != 3'h0);
    assign irq_level = r.il;
    assign arb_bit = r.arb;
endmodule : pwm_channel
`default_nettype wire

// File: hdl/pwm_top.sv
// The address map and register access over APB were chosen for this implementation.
`default_nettype none
module pwm_top
    import pwm_pkg::*;
#(
    parameter int unsigned NUM_SM = pwm_pkg::PWM_NUM_SM
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic module_map_bit,
    output logic [NUM_SM-1:0] pwm_pin,
    output logic [7:1] irq_line,
    input wire logic [2:0] iack_level,
    input wire logic iack_req,
    output logic [3:0] arb_value,
    output logic arb_valid,
    output logic [7:0] vector_out,
    output logic vector_valid
);
    import pwm_pkg::*;

    typedef struct packed {
        logic [7:0] cfg;
        logic div3;
        logic [1:0] pdiv;
        logic [7:0] vector;
        logic vvalid;
        logic [3:0] arb;
        logic avalid;
        logic [31:0] rdata;
        logic [1:0] mm_sync;
    } pwm_top_type;

    pwm_top_type r;
    pwm_top_type next_r;
    logic pclk_en;
    logic acc;
    logic [11:0] off;
    logic [NUM_SM-1:0] sic_we;
    logic [NUM_SM-1:0] per_we;
    logic [NUM_SM-1:0] wid_we;
    logic [15:0] sic_rd [NUM_SM];
    logic [15:0] per_rd [NUM_SM];
    logic [15:0] wid_rd [NUM_SM];
    logic [15:0] cnt_rd [NUM_SM];
    logic [NUM_SM-1:0] req;
    logic [2:0] lvl [NUM_SM];
    logic [NUM_SM-1:0] abit;
    logic addr_hit;

    // module prescaler: system clock over two or three
    assign pclk_en = r.div3 ? (r.pdiv == 2'h2) : (r.pdiv == 2'h1);
    assign acc = psel && penable;
    // upper nibble must be module-map bit then three ones
    assign addr_hit = (paddr[15:12] == {r.mm_sync[1], PWM_ADDR_NIBBLE_ONES[2:0]});
    assign off = paddr[11:0];
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = r.rdata;

    genvar g;
    generate
        for (g = 0; g < NUM_SM; g++)
        begin : g_sm
            localparam logic [11:0] BASE = PWM_BIU_BASE
                + PWM_SM_STRIDE * 12'(int'(PWM_FIRST_SM_NUM) + g);
            logic hit;
            assign hit = acc && pwrite && addr_hit && (off[11:3] == BASE[11:3]);
            // one write strobe per half-word register; the counter has none
            assign sic_we[g] = hit && (off[2:0] == PWM_REG_SIC[2:0]);
            assign per_we[g] = hit && (off[2:0] == PWM_REG_PERIOD[2:0]);
            assign wid_we[g] = hit && (off[2:0] == PWM_REG_WIDTH[2:0]);
            pwm_channel u_ch (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .pclk_en(pclk_en),
                .sic_wdata(pwdata[15:0]),
                .sic_we(sic_we[g]),
                .period_we(per_we[g]),
                .width_we(wid_we[g]),
                .wdata(pwdata[15:0]),
                .sic_rdata(sic_rd[g]),
                .period_rdata(per_rd[g]),
                .width_rdata(wid_rd[g]),
                .count_rdata(cnt_rd[g]),
                .pwm_out(pwm_pin[g]),
                .irq_req(req[g]),
                .irq_level(lvl[g]),
                .arb_bit(abit[g])
            );
        end
    endgenerate

    // each pending request drives the line its level selects
    always_comb
    begin
        irq_line = '0;
        for (int i = 0; i < NUM_SM; i++)
        begin
            if (req[i])
            begin
                irq_line[lvl[i]] = 1'b1;
            end
        end
    end

    always_comb
    begin
        next_r = r;
        next_r.mm_sync = {r.mm_sync[0], module_map_bit};
        next_r.pdiv = pclk_en ? 2'h0 : r.pdiv + 2'h1;
        next_r.vvalid = 1'b0;
        next_r.avalid = 1'b0;
        // fixed priority: scan from highest number so the lowest wins
        if (iack_req)
        begin
            for (int i = NUM_SM - 1; i >= 0; i--)
            begin
                if (req[i] && lvl[i] == iack_level)
                begin
                    next_r.arb = {abit[i], r.cfg[PWM_BIU_ARB_LSB +: 3]};
                    next_r.avalid = 1'b1;
                    next_r.vector = {r.cfg[PWM_BIU_VEC_LSB +: 2],
                        PWM_FIRST_SM_NUM + 6'(i)};
                    next_r.vvalid = 1'b1;
                end
            end
        end
        // register reads; misses and unused bits other than config bits 5:3 answer zero
        next_r.rdata = 32'h0000_0000;
        if (psel && !penable && !pwrite && addr_hit)
        begin
            if (off == PWM_BIU_BASE + PWM_REG_BIU_CFG)
            begin
                next_r.rdata = {24'h000000, r.cfg};
            end
            if (off == PWM_BIU_BASE + PWM_REG_PRESCALE)
            begin
                next_r.rdata = {31'h0, r.div3};
            end
            for (int i = 0; i < NUM_SM; i++)
            begin
                if (off[11:3] == 9'(({27'h0, PWM_BIU_BASE[11:3]}) + PWM_FIRST_SM_NUM + i))
                begin
                    case (off[2:0])
                        3'h0: next_r.rdata = {16'h0000, sic_rd[i]};
                        3'h2: next_r.rdata = {16'h0000, per_rd[i]};
                        3'h4: next_r.rdata = {16'h0000, wid_rd[i]};
                        3'h6: next_r.rdata = {16'h0000, cnt_rd[i]};
                        default: next_r.rdata = 32'h0000_0000;
                    endcase
                end
            end
        end
        if (acc && pwrite && addr_hit)
        begin
            if (off == PWM_BIU_BASE + PWM_REG_BIU_CFG)
            begin
                next_r.cfg = pwdata[7:0];
            end
            if (off == PWM_BIU_BASE + PWM_REG_PRESCALE)
            begin
                next_r.div3 = pwdata[0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign arb_value = r.arb;
    assign arb_valid = r.avalid;
    assign vector_out = r.vector;
    assign vector_valid = r.vvalid;
endmodule : pwm_top
`default_nettype wire

// File: tb/pwm_top_properties.sv
`default_nettype none
module pwm_props
    import pwm_pkg::*;
#(
    parameter int unsigned NUM_SM = 4
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic [NUM_SM-1:0] pwm_pin,
    input wire logic [7:1] irq_line,
    input wire logic [2:0] iack_level,
    input wire logic iack_req,
    input wire logic arb_valid,
    input wire logic [7:0] vector_out,
    input wire logic vector_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wr_q;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // recent writes may move the pin legally, e.g. a polarity change
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            wr_q <= 2'h0;
        else
            wr_q <= {wr_q[0], psel & penable & pwrite};
    end
    a_vec_follow: assert property (iack_req && irq_line[iack_level] |=> vector_valid)
        else $error("no vector after a pending query");
    a_vec_cause: assert property (vector_valid |-> $past(iack_req))
        else $error("vector without a query");
    a_vec_number: assert property (vector_valid |-> vector_out[5:0] inside {[6'h05:6'h08]})
        else $error("vector low bits outside pulse submodules");
    a_arb_pair: assert property (arb_valid == vector_valid)
        else $error("arbitration value and vector out of step");
    a_idle_level: assert property (iack_req && !irq_line[iack_level] |=> !vector_valid)
        else $error("vector for a level with no request");
    a_reset_quiet: assert property (!$past(rst_n) |-> irq_line == 7'h00)
        else $error("request line high after reset");
    a_min_pulse: assert property ($changed(pwm_pin[0]) && wr_q == 2'h0 |=> $stable(pwm_pin[0]))
        else $error("pin pulse shorter than a counter clock");
    a_read_idle: assert property (!psel |-> prdata == 32'h0)
        else $error("read data outside an access");
endmodule // pwm_props
bind pwm_top pwm_props #(.NUM_SM(NUM_SM)) u_props
(
    .core_clk(core_clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .prdata(prdata),
    .pwm_pin(pwm_pin),
    .irq_line(irq_line),
    .iack_level(iack_level),
    .iack_req(iack_req),
    .arb_valid(arb_valid),
    .vector_out(vector_out),
    .vector_valid(vector_valid)
);
`default_nettype wire

// File: tb/pwm_irq_host.sv
`default_nettype none
module pwm_irq_host
(
    input wire logic core_clk,
    input wire logic [3:0] arb_value,
    input wire logic vector_valid,
    input wire logic [7:0] vector_out,
    output logic [2:0] iack_level,
    output logic iack_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // quiet bus until the first query
    initial
    begin
        iack_level = 3'h0;
        iack_req = 1'b0;
    end
    // one query of a level; answer taken only at the edges that sample it
    task automatic ack(input logic [2:0] lvl, output logic [7:0] vec, output logic [3:0] arb,
        output logic got);
        int i;
        got = 1'b0;
        vec = 8'h00;
        arb = 4'h0;
        @(posedge core_clk);
        iack_level <= lvl;
        iack_req <= 1'b1;
        @(posedge core_clk);
        iack_req <= 1'b0;
        iack_level <= ~lvl; // a stale level is not left on the bus
        for (i = 0; i < 3; i++)
        begin
            @(posedge core_clk);
            if (!got && vector_valid === 1'b1)
            begin
                got = 1'b1;
                vec = vector_out;
                arb = arb_value;
            end
        end
    endtask
endmodule // pwm_irq_host
`default_nettype wire

// File: tb/test_pwm_submodule_irq_vectoring.sv
`default_nettype none
module test_pwm_submodule_irq_vectoring;
    import pwm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk;
    logic rst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic err;
    logic mm;
    logic [3:0] pin;
    logic [7:1] irq_line;
    logic [2:0] iack_level;
    logic iack_req;
    logic [3:0] arb_value;
    logic [7:0] vector_out;
    logic vector_valid;
    logic [15:0] r;
    int n_fail = 0;
    int cmp_count = 0;
    pwm_top dut
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .module_map_bit(mm),
        .pwm_pin(pin),
        .irq_line(irq_line),
        .iack_level(iack_level),
        .iack_req(iack_req),
        .arb_value(arb_value),
        .arb_valid(),
        .vector_out(vector_out),
        .vector_valid(vector_valid)
    );
    pwm_irq_host host
    (
        .core_clk(core_clk),
        .arb_value(arb_value),
        .vector_valid(vector_valid),
        .vector_out(vector_out),
        .iack_level(iack_level),
        .iack_req(iack_req)
    );
    // 125 MHz core clock
    always #4 core_clk = ~core_clk;
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // setup, then access held until pready is sampled high
    task automatic apb(input logic w, input logic [15:0] a, input logic [15:0] d,
        output logic [15:0] rd);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            n_fail++;
        rd = prdata[15:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // register address inside the mapped window
    function automatic logic [15:0] ad(input logic [11:0] sm, input logic [11:0] off);
        return {mm, 3'h7, PWM_BIU_BASE + PWM_SM_STRIDE * sm + off};
    endfunction
    // counts samples equal to v, one already seen
    task automatic run(input logic v, output int n);
        n = 1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pin[0] === v && n < 3000);
        n--;
    endtask
    task automatic t_regs();
        logic [11:0] s;
        apb(1'b0, ad(12'h005, PWM_REG_COUNT), 16'h0000, r);
        chk("count at reset", 16'h0001, r);
        for (s = 12'h005; s <= 12'h008; s++)
            apb(1'b1, ad(s, PWM_REG_PERIOD), {12'h010, s[3:0]}, r);
        apb(1'b1, ad(12'h005, PWM_REG_COUNT), 16'h1234, r);
        apb(1'b1, ad(12'h005, PWM_REG_PERIOD) ^ 16'h8000, 16'hbeef, r);
        for (s = 12'h005; s <= 12'h008; s++)
        begin
            apb(1'b0, ad(s, PWM_REG_PERIOD), 16'h0000, r);
            chk("period readback", {12'h010, s[3:0]}, r);
        end
        apb(1'b0, ad(12'h005, PWM_REG_COUNT), 16'h0000, r);
        chk("count after write", 16'h0001, r);
        // the other mirrored region once the map bit has settled
        mm <= 1'b1;
        repeat (3) @(posedge core_clk);
        apb(1'b0, ad(12'h008, PWM_REG_PERIOD), 16'h0000, r);
        chk("mirror read", 16'h0108, r);
        mm <= 1'b0;
        repeat (3) @(posedge core_clk);
        apb(1'b1, ad(12'h009, 12'h000), 16'hffff, r);
        apb(1'b0, ad(12'h009, 12'h000), 16'h0000, r);
        chk("reserved read", 16'h0000, r);
        chk("slave error", 16'h0000, {15'h0000, err});
        apb(1'b1, ad(12'h005, PWM_REG_SIC), 16'h0780, r);
        apb(1'b0, ad(12'h005, PWM_REG_SIC), 16'h0000, r);
        chk("unused bits", 16'h0000, r & 16'hffbf);
    endtask
    // one clean low-high-low cycle after an immediate load
    task automatic t_wave(input logic [15:0] per, input logic [15:0] wid, input int hi,
        input int lo);
        int n;
        int h;
        int l;
        apb(1'b1, ad(12'h005, PWM_REG_PERIOD), per, r);
        apb(1'b1, ad(12'h005, PWM_REG_WIDTH), wid, r);
        apb(1'b1, ad(12'h005, PWM_REG_SIC), 16'h0038, r);
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pin[0] !== 1'b0 && n < 3000);
        run(1'b0, n);
        run(1'b1, h);
        run(1'b0, l);
        chk("pulse high", 16'(hi), 16'(h));
        chk("pulse low", 16'(lo), 16'(l));
    endtask
    // steady level over several periods while the counter keeps moving
    task automatic t_steady(input logic [15:0] wid, input logic [15:0] sic, input logic lvl);
        int i;
        int bad;
        apb(1'b1, ad(12'h005, PWM_REG_WIDTH), wid, r);
        apb(1'b1, ad(12'h005, PWM_REG_SIC), sic, r);
        bad = 0;
        repeat (3) @(posedge core_clk);
        for (i = 0; i < 40; i++)
        begin
            @(posedge core_clk);
            if (pin[0] !== lvl)
                bad++;
        end
        chk("steady level", 16'h0000, 16'(bad));
        apb(1'b0, ad(12'h005, PWM_REG_COUNT), 16'h0000, r);
        i = r;
        apb(1'b0, ad(12'h005, PWM_REG_COUNT), 16'h0000, r);
        chk("count runs", 16'h0001, 16'(r != 16'(i)));
        // a counter write while running must not move it out of the period
        apb(1'b1, ad(12'h005, PWM_REG_COUNT), 16'h1234, r);
        apb(1'b0, ad(12'h005, PWM_REG_COUNT), 16'h0000, r);
        chk("count write ignored", 16'h0001, 16'(r != 16'h0000 && r <= 16'h0004));
    endtask
    // two sources on one level, then the lower one withdrawn
    task automatic t_irq();
        logic [7:0] v;
        logic [3:0] a;
        logic g;
        apb(1'b1, ad(12'h000, PWM_REG_BIU_CFG), 16'h00c5, r);
        apb(1'b1, ad(12'h006, PWM_REG_PERIOD), 16'h0004, r);
        apb(1'b1, ad(12'h006, PWM_REG_SIC), 16'h3038, r);
        apb(1'b1, ad(12'h005, PWM_REG_SIC), 16'h3038, r);
        repeat (20) @(posedge core_clk);
        chk("request lines", 16'h0004, {9'h000, irq_line});
        host.ack(3'h3, v, a, g);
        chk("vector both pending", 16'h01c5, {7'h00, g, v});
        chk("arbitration value", 16'h0005, {12'h000, a});
        host.ack(3'h5, v, a, g);
        chk("vector idle level", 16'h0000, {7'h00, g, v});
        apb(1'b1, ad(12'h005, PWM_REG_SIC), 16'h0000, r);
        host.ack(3'h3, v, a, g);
        chk("vector after clear", 16'h01c6, {7'h00, g, v});
        apb(1'b1, ad(12'h006, PWM_REG_SIC), 16'h0038, r);
        repeat (10) @(posedge core_clk);
        chk("lines at level zero", 16'h0000, {9'h000, irq_line});
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // main sequence
    initial
    begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0;
        mm = 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        t_regs();
        t_wave(16'h0004, 16'h0001, 2, 6);
        t_wave(16'h0004, 16'h0003, 6, 2);
        apb(1'b1, ad(12'h000, PWM_REG_PRESCALE), 16'h0001, r);
        t_wave(16'h0004, 16'h0001, 3, 9);
        apb(1'b1, ad(12'h000, PWM_REG_PRESCALE), 16'h0000, r);
        t_steady(16'h0000, 16'h0038, 1'b0);
        t_steady(16'h0005, 16'h0038, 1'b1);
        t_steady(16'h0000, 16'h0018, 1'b1);
        t_irq();
        results();
    end
    // hang guard, far beyond the expected run
    initial
    begin
        #400000;
        n_fail++;
        results();
    end
endmodule // test_pwm_submodule_irq_vectoring
`default_nettype wire
